/* psq_core.sv */
// Operation
// - four phases form one instruction cycle
// - first phase advances counter and fetches
// - fetch overlaps execute; branches cost one extra
// - counter steps by one when sequential
// - eleven-bit counter, low byte software visible
// - jumps, calls, interrupts, reset load target
// - taken skip discards prefetched word, dummy cycle
// - low-byte write jumps in page, dummy cycle
// - six-level stack, hidden from software
// - call/interrupt push, returns pop counter
// - reset empties the stack
// - full stack defers interrupt until return
// - call on full stack still executes
// - eight-bit alu updates status flags
// - add, sub, adjust, logic, rotate, step
// - 2K sixteen-bit words, top 16 reserved
// - separate table pointer addresses table data
// - reset starts execution at address zero
// - table read takes two instruction cycles
`timescale 1ns/1ps
module psq_core
  import psq_pkg::*;
#(
  parameter logic [10:0] IRQ_VECTOR = PSQ_IRQ_VECTOR
)
(
  input wire logic mclk,
  input wire logic reset_n,
  output logic [10:0] prog_addr,
  input wire logic [15:0] prog_data,
  output logic [7:0] dm_addr,
  input wire logic [7:0] dm_rdata,
  output logic [7:0] dm_wdata,
  output logic dm_we,
  input wire logic irq_req,
  output logic irq_ack,
  output logic irq_return,
  output logic [3:0] cycle_phase_clocks,
  output logic [7:0] acc,
  output logic [3:0] status,
  output logic [7:0] tblh
);

  psq_phase_e phase_ff;
  logic [3:0] phase_oh_ff;
  logic [10:0] pc_ff, prog_addr_ff, ir_addr_ff, tbl_ptr_ff;
  logic [15:0] ir_ff;
  logic ir_valid_ff, stall_ff, boot_ff;
  logic [7:0] acc_ff, tblh_ff, dm_addr_ff, dm_wdata_ff;
  logic dm_we_ff, irq_pend_ff, irq_ack_ff, irq_ret_ff;
  logic [3:0] status_ff;
  logic [10:0] stack_mem [int'(PSQ_STACK_LEVELS)];
  logic [2:0] sp_ff, depth_ff;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  psq_op_e op;
  psq_alu_e alu_sel;
  logic t1, commit, exec, is_jmp, is_call, is_ret, is_pcl_wr, is_tbl_rd;
  logic skip_taken, flow, stack_full, irq_take, push, pop, flush, alu_upd;
  logic [7:0] operand, alu_res, pc_low_byte_reg;
  logic [3:0] alu_st;
  logic [10:0] ret_addr, stack_top, nxt_pc_branch;
  logic [2:0] sp_inc, sp_dec;
  logic reserved_fetch;

  assign op = psq_op_e'(ir_ff[15:12]);
  assign alu_sel = psq_alu_e'(ir_ff[11:8]);
  assign t1 = (phase_ff == PSQ_T1);
  assign commit = (phase_ff == PSQ_T4);
  assign exec = commit & ir_valid_ff & ~stall_ff;
  assign is_jmp = exec & (op == PSQ_OP_JUMP);
  assign is_call = exec & (op == PSQ_OP_CALL);
  assign is_ret = exec & ((op == PSQ_OP_RET) | (op == PSQ_OP_INTERRUPT_RETURN));
  assign is_pcl_wr = exec & (op == PSQ_OP_PCL_WR);
  assign is_tbl_rd = exec & (op == PSQ_OP_TBL_RD);
  assign skip_taken = exec & (op == PSQ_OP_SKIPZ) & (alu_res == 8'h00);
  assign flow = is_jmp | is_call | is_ret | is_pcl_wr | is_tbl_rd | skip_taken;
  assign stack_full = (depth_ff == PSQ_STACK_LEVELS);
  assign irq_take = exec & irq_pend_ff & ~stack_full & ~flow;
  assign push = is_call | irq_take;
  assign pop = is_ret;
  assign flush = flow & ~is_tbl_rd | irq_take;
  assign alu_upd = exec & ((op == PSQ_OP_ALU_IMM) | (op == PSQ_OP_ALU_MEM)
                           | (op == PSQ_OP_ALU_MEMW));
  assign operand = (op == PSQ_OP_ALU_IMM) ? ir_ff[7:0] : dm_rdata;
  assign ret_addr = ir_addr_ff + 11'h001;
  assign pc_low_byte_reg = ret_addr[7:0];
  assign sp_inc = (sp_ff == PSQ_STACK_LEVELS - 3'h1) ? 3'h0 : sp_ff + 3'h1;
  assign sp_dec = (sp_ff == 3'h0) ? PSQ_STACK_LEVELS - 3'h1 : sp_ff - 3'h1;
  assign stack_top = stack_mem[sp_dec];
  assign reserved_fetch = (prog_addr_ff >= PSQ_PM_RESERVED_BASE);

  // branch target, interrupt first
  assign nxt_pc_branch = irq_take ? IRQ_VECTOR :
                         (is_jmp | is_call) ? ir_ff[10:0] :
                         is_ret ? stack_top :
                         is_pcl_wr ? {ir_addr_ff[10:8], acc_ff} :
                         pc_ff;

  // ------------------------------------------------------------
  // alu
  // ------------------------------------------------------------
  logic [8:0] sum9, daa_t, daa_r;
  logic [4:0] half5;
  logic [7:0] addend;
  logic cin, is_sub;

  assign is_sub = (alu_sel == PSQ_ALU_SUB) | (alu_sel == PSQ_ALU_SBC);
  assign addend = is_sub ? ~operand : operand;
  assign cin = (alu_sel == PSQ_ALU_SUB) ? 1'b1 :
               ((alu_sel == PSQ_ALU_ADC) | (alu_sel == PSQ_ALU_SBC))
               ? status_ff[PSQ_ST_C] : 1'b0;
  assign sum9 = {1'b0, acc_ff} + {1'b0, addend} + {8'h00, cin};
  assign half5 = {1'b0, acc_ff[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
  assign daa_t = {1'b0, acc_ff} + ((acc_ff[3:0] > 4'h9 | status_ff[PSQ_ST_AC])
                 ? 9'h006 : 9'h000);
  assign daa_r = daa_t + ((daa_t[7:4] > 4'h9 | daa_t[8] | status_ff[PSQ_ST_C])
                 ? 9'h060 : 9'h000);

  // result and new flags
  always_comb
  begin
    alu_res = operand;
    alu_st = status_ff;
    unique case (alu_sel)
      PSQ_ALU_ADD, PSQ_ALU_ADC, PSQ_ALU_SUB, PSQ_ALU_SBC:
      begin
        alu_res = sum9[7:0];
        alu_st[PSQ_ST_C] = sum9[8];
        alu_st[PSQ_ST_AC] = half5[4];
        alu_st[PSQ_ST_OV] = (acc_ff[7] == addend[7]) & (sum9[7] != acc_ff[7]);
      end
      PSQ_ALU_DAA:
      begin
        alu_res = daa_r[7:0];
        alu_st[PSQ_ST_C] = daa_r[8] | status_ff[PSQ_ST_C];
      end
      PSQ_ALU_AND: alu_res = acc_ff & operand;
      PSQ_ALU_OR: alu_res = acc_ff | operand;
      PSQ_ALU_XOR: alu_res = acc_ff ^ operand;
      PSQ_ALU_CPL: alu_res = ~operand;
      PSQ_ALU_RR: alu_res = {operand[0], operand[7:1]};
      PSQ_ALU_RRC:
      begin
        alu_res = {status_ff[PSQ_ST_C], operand[7:1]};
        alu_st[PSQ_ST_C] = operand[0];
      end
      PSQ_ALU_RL: alu_res = {operand[6:0], operand[7]};
      PSQ_ALU_RLC:
      begin
        alu_res = {operand[6:0], status_ff[PSQ_ST_C]};
        alu_st[PSQ_ST_C] = operand[7];
      end
      PSQ_ALU_INC: alu_res = operand + 8'h01;
      PSQ_ALU_DEC: alu_res = operand - 8'h01;
      PSQ_ALU_MOV: alu_res = operand;
    endcase
    alu_st[PSQ_ST_Z] = (alu_res == 8'h00);
  end

  // ------------------------------------------------------------
  // phase generator
  // ------------------------------------------------------------
  // four phases per cycle, one-hot copy to the pins
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      phase_ff <= PSQ_T1;
      phase_oh_ff <= 4'h1;
    end
    else
    begin
      phase_ff <= psq_phase_e'(phase_ff + 2'b01);
      phase_oh_ff <= {phase_oh_ff[2:0], phase_oh_ff[3]};
    end
  end

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  // fetch at T1, commit and prefetch latch at T4
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pc_ff <= PSQ_RESET_VECTOR;
      prog_addr_ff <= PSQ_RESET_VECTOR;
      ir_ff <= PSQ_NOP_WORD;
      ir_addr_ff <= PSQ_RESET_VECTOR;
      ir_valid_ff <= 1'b0;
      stall_ff <= 1'b0;
      dm_addr_ff <= 8'h00;
      boot_ff <= 1'b1;
    end
    else if (t1)
    begin
      boot_ff <= 1'b0;
      dm_addr_ff <= ir_ff[7:0];
      if (stall_ff)
        prog_addr_ff <= tbl_ptr_ff;
      else
      begin
        prog_addr_ff <= pc_ff;
        pc_ff <= pc_ff + 11'h001;
      end
    end
    else if (commit)
    begin
      pc_ff <= nxt_pc_branch;
      stall_ff <= is_tbl_rd;
      if (!stall_ff)
      begin
        ir_ff <= prog_data;
        ir_addr_ff <= prog_addr_ff;
        ir_valid_ff <= ~flush & ~reserved_fetch;
      end
    end
  end

  // ------------------------------------------------------------
  // data path registers
  // ------------------------------------------------------------
  // accumulator, flags, table pointer and data memory write
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc_ff <= 8'h00;
      status_ff <= 4'h0;
      tbl_ptr_ff <= 11'h000;
      tblh_ff <= 8'h00;
      dm_we_ff <= 1'b0;
      dm_wdata_ff <= 8'h00;
    end
    else
    begin
      dm_we_ff <= exec & ((op == PSQ_OP_ALU_MEMW) | (op == PSQ_OP_SKIPZ));
      dm_wdata_ff <= alu_res;
      if (alu_upd)
        status_ff <= alu_st;
      if (exec & ((op == PSQ_OP_ALU_IMM) | (op == PSQ_OP_ALU_MEM)))
        acc_ff <= alu_res;
      else if (exec & (op == PSQ_OP_PCL_RD))
        acc_ff <= pc_low_byte_reg;
      else if (commit & stall_ff)
      begin
        acc_ff <= prog_data[7:0];
        tblh_ff <= prog_data[15:8];
      end
      if (exec & (op == PSQ_OP_TBL_SET))
        tbl_ptr_ff <= {ir_ff[10:8], acc_ff};
    end
  end

  // ------------------------------------------------------------
  // return stack and interrupt handshake
  // ------------------------------------------------------------
  // pointer circular on overflow, depth saturates at full
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sp_ff <= 3'h0;
      depth_ff <= 3'h0;
      irq_pend_ff <= 1'b0;
      irq_ack_ff <= 1'b0;
      irq_ret_ff <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        sp_ff <= sp_inc;
        depth_ff <= stack_full ? depth_ff : depth_ff + 3'h1;
      end
      else if (pop)
      begin
        sp_ff <= sp_dec;
        depth_ff <= (depth_ff == 3'h0) ? 3'h0 : depth_ff - 3'h1;
      end
      irq_pend_ff <= irq_req | (irq_pend_ff & ~irq_take);
      irq_ack_ff <= irq_take;
      irq_ret_ff <= exec & (op == PSQ_OP_INTERRUPT_RETURN);
    end
  end

  // stack storage, no reset needed
  always_ff @(posedge mclk)
  begin
    if (push)
      stack_mem[sp_ff] <= ret_addr;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prog_addr = prog_addr_ff;
  assign dm_addr = dm_addr_ff;
  assign dm_wdata = dm_wdata_ff;
  assign dm_we = dm_we_ff;
  assign irq_ack = irq_ack_ff;
  assign irq_return = irq_ret_ff;
  assign cycle_phase_clocks = phase_oh_ff;
  assign acc = acc_ff;
  assign status = status_ff;
  assign tblh = tblh_ff;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_phase_walk;
    phase_oh_ff[1] ##1 phase_oh_ff[2] ##1 phase_oh_ff[3] ##1 phase_oh_ff[0];
  endsequence

  a_phase_order:
    assert property (reset_n && phase_oh_ff[0] |=> s_phase_walk)
    else $error("phase clocks out of order");
  a_fetch_step:
    assert property (reset_n && t1 && !stall_ff |=> prog_addr_ff == $past(pc_ff)
                     && pc_ff == $past(pc_ff) + 11'h001)
    else $error("sequential fetch did not step by one");
  a_boot_vector:
    assert property (boot_ff && t1 |=> prog_addr_ff == PSQ_RESET_VECTOR
                     && depth_ff == 3'h0)
    else $error("first fetch after reset not at zero");
  a_jump_dummy:
    assert property (is_jmp |=> !ir_valid_ff && pc_ff == $past(ir_ff[10:0]))
    else $error("jump without target load or dummy cycle");
  a_skip_discard:
    assert property (skip_taken |=> !ir_valid_ff && pc_ff == $past(pc_ff))
    else $error("taken skip kept prefetched word");
  a_pcl_page:
    assert property (is_pcl_wr |=> !ir_valid_ff
                     && pc_ff == {$past(ir_addr_ff[10:8]), $past(acc_ff)})
    else $error("low byte write left page or skipped dummy");
  a_irq_defer:
    assert property (irq_ack_ff |-> pc_ff == IRQ_VECTOR
                     && $past(depth_ff) != PSQ_STACK_LEVELS)
    else $error("interrupt taken with full stack");
  a_call_full:
    assert property (is_call && stack_full |=> stack_full && sp_ff == $past(sp_inc))
    else $error("call on full stack mishandled");
  a_table_two:
    assert property (is_tbl_rd |=> stall_ff [*4] ##1 !stall_ff)
    else $error("table read not two cycles");
  a_alu_zero:
    assert property (alu_upd |=> status_ff[PSQ_ST_Z] == ($past(alu_res) == 8'h00))
    else $error("zero flag not updated");

endmodule : psq_core

/* psq_pkg.sv */
package psq_pkg;

  // ------------------------------------------------------------
  // sizes and vectors
  // ------------------------------------------------------------
  localparam logic [10:0] PSQ_RESET_VECTOR = 11'h000;
  localparam logic [10:0] PSQ_IRQ_VECTOR = 11'h004;
  localparam logic [10:0] PSQ_PM_RESERVED_BASE = 11'h7F0;
  localparam logic [2:0] PSQ_STACK_LEVELS = 3'h6;
  localparam logic [15:0] PSQ_NOP_WORD = 16'hF000;

  // status flag positions
  localparam int PSQ_ST_C = 0;
  localparam int PSQ_ST_AC = 1;
  localparam int PSQ_ST_Z = 2;
  localparam int PSQ_ST_OV = 3;

  // ------------------------------------------------------------
  // instruction word layout: op [15:12], alu [11:8], operand [7:0]
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    PSQ_OP_ALU_IMM = 4'h0,
    PSQ_OP_ALU_MEM = 4'h1,
    PSQ_OP_ALU_MEMW = 4'h2,
    PSQ_OP_JUMP = 4'h3,
    PSQ_OP_CALL = 4'h4,
    PSQ_OP_RET = 4'h5,
    PSQ_OP_INTERRUPT_RETURN = 4'h6,
    PSQ_OP_SKIPZ = 4'h7,
    PSQ_OP_PCL_WR = 4'h8,
    PSQ_OP_PCL_RD = 4'h9,
    PSQ_OP_TBL_SET = 4'hA,
    PSQ_OP_TBL_RD = 4'hB,
    PSQ_OP_NOP = 4'hF
  } psq_op_e;

  typedef enum logic [3:0] {
    PSQ_ALU_ADD = 4'h0,
    PSQ_ALU_ADC = 4'h1,
    PSQ_ALU_SUB = 4'h2,
    PSQ_ALU_SBC = 4'h3,
    PSQ_ALU_DAA = 4'h4,
    PSQ_ALU_AND = 4'h5,
    PSQ_ALU_OR = 4'h6,
    PSQ_ALU_XOR = 4'h7,
    PSQ_ALU_CPL = 4'h8,
    PSQ_ALU_RR = 4'h9,
    PSQ_ALU_RRC = 4'hA,
    PSQ_ALU_RL = 4'hB,
    PSQ_ALU_RLC = 4'hC,
    PSQ_ALU_INC = 4'hD,
    PSQ_ALU_DEC = 4'hE,
    PSQ_ALU_MOV = 4'hF
  } psq_alu_e;

  typedef enum logic [1:0] {
    PSQ_T1 = 2'b00,
    PSQ_T2 = 2'b01,
    PSQ_T3 = 2'b10,
    PSQ_T4 = 2'b11
  } psq_phase_e;

endpackage : psq_pkg

/* psq_mem_model.sv */
`timescale 1ns/1ps
module psq_mem_model
  import psq_pkg::*;
(
  input wire logic mclk,
  input wire logic [10:0] prog_addr,
  output logic [15:0] prog_data,
  input wire logic [7:0] dm_addr,
  output logic [7:0] dm_rdata,
  input wire logic [7:0] dm_wdata,
  input wire logic dm_we
);
  // ------------------------------------------------------------
  // storage, filled by the bench before reset release
  // ------------------------------------------------------------
  logic [15:0] rom [0:2047];
  logic [7:0] ram [0:255];

  // combinational reads of program word and data byte
  assign prog_data = rom[prog_addr];
  assign dm_rdata = ram[dm_addr];

  // data write on the write pulse
  always @(posedge mclk)
  begin
    if (dm_we === 1'b1)
      ram[dm_addr] <= dm_wdata;
  end
endmodule : psq_mem_model

/* program_sequencer_core_tb.sv */
`timescale 1ns/1ps
module program_sequencer_core_tb
  import psq_pkg::*;
;
  logic mclk, reset_n, irq_req, irq_ack, irq_return, dm_we;
  logic [10:0] prog_addr;
  logic [15:0] prog_data;
  logic [7:0] dm_addr, dm_rdata, dm_wdata, acc, tblh;
  logic [3:0] cycle_phase_clocks, status;
  logic [10:0] a_q [$];
  logic [7:0] c_q [$];
  logic [3:0] s_q [$];
  int n_errors = 0;
  int check_count = 0;
  int n_ack = 0;
  int n_ret = 0;
  int ack_idx = -1;
  int i, k, deep;
  // address and word pairs of the test program
  // the vector jumps to an alu routine at 030 that ends in an interrupt return
  localparam logic [26:0] PROG [33] = '{
    {11'h000, 16'h0F05}, {11'h001, 16'h00FB}, {11'h002, 16'h4010}, {11'h003, 16'h3020},
    {11'h004, 16'h3030}, {11'h010, 16'h9000}, {11'h011, 16'h5000}, {11'h020, 16'h0F3C},
    {11'h021, 16'h050F}, {11'h022, 16'h0630}, {11'h023, 16'h07FF}, {11'h024, 16'h080F},
    {11'h025, 16'h0DFF}, {11'h026, 16'h0E00}, {11'h027, 16'h0201}, {11'h028, 16'h0042},
    {11'h029, 16'h8000}, {11'h040, 16'h7E30}, {11'h041, 16'h0F99}, {11'h042, 16'h0F07},
    {11'h043, 16'hA700}, {11'h044, 16'hB000}, {11'h045, 16'h3060}, {11'h071, 16'h5000},
    {11'h707, 16'h5AC3}, {11'h030, 16'h0F15}, {11'h031, 16'h0027}, {11'h032, 16'h0400},
    {11'h033, 16'h0C81}, {11'h034, 16'h0A03}, {11'h035, 16'h1101}, {11'h036, 16'h2D31},
    {11'h037, 16'h6000}};
  localparam logic [7:0] ALU_EXP [9] = '{8'h3C, 8'h0C, 8'h3C, 8'hC3, 8'hF0, 8'h00, 8'hFF,
    8'hFE, 8'h40};
  // mov, add, decimal adjust, rotate through carry both ways, adc from memory, inc to memory
  localparam logic [7:0] ISR_EXP [7] = '{8'h15, 8'h3C, 8'h42, 8'h02, 8'h81, 8'h82, 8'h82};

  psq_core u_dut (.mclk(mclk), .reset_n(reset_n), .prog_addr(prog_addr),
    .prog_data(prog_data), .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata),
    .dm_we(dm_we), .irq_req(irq_req), .irq_ack(irq_ack), .irq_return(irq_return),
    .cycle_phase_clocks(cycle_phase_clocks), .acc(acc), .status(status), .tblh(tblh));

  psq_mem_model u_mem (.mclk(mclk), .prog_addr(prog_addr), .prog_data(prog_data),
    .dm_addr(dm_addr), .dm_rdata(dm_rdata), .dm_wdata(dm_wdata), .dm_we(dm_we));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // first cycle at or after from that fetched ad, -1 if none
  function automatic int fa(input logic [10:0] ad, input int from);
    for (int j = (from < 0) ? 0 : from; j < a_q.size(); j++)
      if (a_q[j] === ad)
        return j;
    return -1;
  endfunction : fa

  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // clock at 40 MHz
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // one log entry per instruction cycle, taken in the second phase
  always @(posedge mclk)
  begin
    if (cycle_phase_clocks === 4'b0010)
    begin
      a_q.push_back(prog_addr);
      c_q.push_back(acc);
      s_q.push_back(status);
    end
    if (irq_ack === 1'b1)
    begin
      n_ack++;
      ack_idx = a_q.size();
    end
    if (irq_return === 1'b1)
      n_ret++;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    irq_req = 1'b0;
    for (i = 0; i < 2048; i++)
      u_mem.rom[i] = PSQ_NOP_WORD;
    for (i = 0; i < 256; i++)
      u_mem.ram[i] = 8'h00;
    u_mem.ram[8'h30] = 8'h01;
    foreach (PROG[n])
      u_mem.rom[PROG[n][26:16]] = PROG[n][15:0];
    // nested call chain, seven deep, each callee returns right after its call
    for (i = 0; i < 7; i++)
    begin
      u_mem.rom[11'(8'h60 + 2 * i)] = 16'h4000 | 16'(8'h62 + 2 * i);
      u_mem.rom[11'(8'h61 + 2 * i)] = 16'h5000;
    end
    // innermost return site is plain, so the deferred request lands there
    u_mem.rom[11'h06D] = PSQ_NOP_WORD;
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    // raise a request once the stack is full
    for (i = 0; i < 3000 && prog_addr !== 11'h06E; i++)
      @(posedge mclk);
    if (i == 3000)
    begin
      n_errors++;
      wrap_up();
    end
    irq_req <= 1'b1;
    @(posedge mclk);
    irq_req <= 1'b0;
    for (i = 0; i < 2000 && n_ret == 0; i++)
      @(posedge mclk);
    if (i == 2000)
    begin
      n_errors++;
      wrap_up();
    end
    // let the unwind after the interrupt return reach the outer frames
    repeat (80) @(posedge mclk);
    // sequencing and results
    check("reset fetch", 16'(a_q[0]), 16'h0000);
    check("step one", 16'(fa(11'h001, 0) - fa(11'h000, 0)), 16'h0001);
    check("step two", 16'(fa(11'h002, 0) - fa(11'h001, 0)), 16'h0001);
    k = fa(11'h001, 0);
    check("add result", 16'(c_q[k + 2]), 16'h0000);
    check("add flags", 16'({s_q[k + 2][PSQ_ST_Z], s_q[k + 2][PSQ_ST_C]}), 16'h0003);
    check("call delay", 16'(fa(11'h010, 0) - fa(11'h002, 0)), 16'h0002);
    check("low byte read", 16'(c_q[fa(11'h010, 0) + 2]), 16'h0011);
    k = fa(11'h011, 0);
    check("return delay", 16'(fa(11'h003, k) - k), 16'h0002);
    check("jump delay", 16'(fa(11'h020, 0) - fa(11'h003, k)), 16'h0002);
    for (i = 0; i < 9; i++)
      check("alu acc", 16'(c_q[fa(11'(32 + i), 0) + 2]), 16'(ALU_EXP[i]));
    check("sub carry", 16'(s_q[fa(11'h027, 0) + 2][PSQ_ST_C]), 16'h0001);
    check("page jump", 16'(fa(11'h040, 0) - fa(11'h029, 0)), 16'h0002);
    k = fa(11'h042, 0);
    check("skip delay", 16'(k - fa(11'h040, 0)), 16'h0002);
    check("skipped word", 16'(c_q[k + 1]), 16'h0040);
    check("after skip", 16'(c_q[k + 2]), 16'h0007);
    check("skip write", 16'(u_mem.ram[8'h30]), 16'h0000);
    k = fa(11'h707, 0);
    check("table fetch", 16'(k - fa(11'h044, 0)), 16'h0002);
    check("table low", 16'(c_q[k + 1]), 16'h00C3);
    check("table high", 16'(tblh), 16'h005A);
    for (i = 0; i < 7; i++)
      check("isr acc", 16'(c_q[fa(11'(48 + i), 0) + 2]), 16'(ISR_EXP[i]));
    check("rlc carry", 16'(s_q[fa(11'h033, 0) + 2][PSQ_ST_C]), 16'h0001);
    check("mem write", 16'(u_mem.ram[8'h31]), 16'h0001);
    check("phase one-hot", 16'($countones(cycle_phase_clocks)), 16'h0001);
    deep = fa(11'h06E, 0);
    check("oldest lost", 16'(fa(11'h061, deep)), 16'hFFFF);
    check("five kept", 16'(fa(11'h063, deep) > fa(11'h06B, deep)), 16'h0001);
    k = fa(11'h071, deep);
    check("ack deferred", 16'(ack_idx >= k + 2 && ack_idx <= k + 12), 16'h0001);
    check("ack count", 16'(n_ack), 16'h0001);
    check("vector fetch", 16'(fa(11'h004, deep) > k), 16'h0001);
    check("int return", 16'(n_ret), 16'h0001);
    wrap_up();
  end
endmodule : program_sequencer_core_tb
